// File: inc/sxe_defs.svh
// Purpose: offsets, field positions, reset values and counts of the execution block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef SXE_DEFS_SVH
`define SXE_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SXE_ADDR_W        12
`define SXE_OFS_EXEC      12'h000
`define SXE_OFS_WORK      12'h004
`define SXE_OFS_STATUS    12'h008
`define SXE_OFS_DIR       12'h00C
`define SXE_OFS_WDT       12'h010
`define SXE_OFS_WDT_CTRL  12'h014
`define SXE_OFS_FADDR     12'h018
`define SXE_OFS_FDATA     12'h01C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SXE_EXEC_OP_LSB   0
`define SXE_EXEC_OP_MSB   3
`define SXE_EXEC_DEST_BIT 4
`define SXE_EXEC_FA_LSB   8
`define SXE_EXEC_FA_MSB   14
`define SXE_EXEC_LIT_LSB  16
`define SXE_EXEC_LIT_MSB  23
`define SXE_ST_C          0
`define SXE_ST_DC         1
`define SXE_ST_Z          2
`define SXE_ST_PD         3
`define SXE_ST_TO         4
`define SXE_DIR_A_LSB     0
`define SXE_DIR_B_LSB     8
`define SXE_DIR_C_LSB     16

// ----------------------------------------------------------------
// operand values, reset values, counts
// ----------------------------------------------------------------
`define SXE_LOAD_DIRECTION_INSTR_SEL_A    7'h05
`define SXE_LOAD_DIRECTION_INSTR_SEL_B    7'h06
`define SXE_LOAD_DIRECTION_INSTR_SEL_C    7'h07
`define SXE_WORK_RST      8'h00
`define SXE_PD_RST        1'b1
`define SXE_TO_RST        1'b1
`define SXE_DIR_RST       8'hFF
`define SXE_WDT_CLR       8'h00
`define SXE_PRESC_CLR     8'h00
`define SXE_PRESC_MAX     8'hFF
`define SXE_FILE_DEPTH    128

`endif

// File: inc/sxe_pkg.sv
// Purpose: types shared by the execution block
// Assumes: constants live in sxe_defs.svh
// Notes:   opcode codes are the values software writes into the exec register
package sxe_pkg;

  typedef enum logic [3:0] {
    OP_NOP          = 4'h0,
    OP_SLEEP        = 4'h1,
    OP_SUB_WF       = 4'h2,
    OP_SUB_LW       = 4'h3,
    OP_SUB_WFB      = 4'h4,
    OP_NIBBLE_SWAP  = 4'h5,
    OP_LOAD_DIR     = 4'h6,
    OP_XOR_LIT      = 4'h7,
    OP_XOR_FILE     = 4'h8
  } sxe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } sxe_state_t;

endpackage

// File: inc/sxe_mem_if.sv
// Purpose: port of the file register memory
// Assumes: read data valid the cycle after a read enable
// Notes:   one port, shared by the engine and the bus
`timescale 1ns/10ps
interface sxe_mem_if;
  logic       en;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// File: rtl/sxe_file_mem.sv
// Purpose: 128 x 8 file register store
// Assumes: single port, synchronous read into a register
// Notes:   write and read never in the same cycle by construction
`timescale 1ns/10ps
`include "sxe_defs.svh"
module sxe_file_mem
  import sxe_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // memory port
  sxe_mem_if.mem   port
);

  logic [7:0] store [0:`SXE_FILE_DEPTH-1];
  logic [7:0] rdata_q;

  always_ff @(posedge clk_sys) begin
    if (port.en && port.we) begin
      store[port.addr] <= port.wdata;
    end
    if (port.en && !port.we) begin
      rdata_q <= store[port.addr];
    end
  end

  assign port.rdata = rdata_q;

endmodule // sxe_file_mem

// File: rtl/sxe_wdt.sv
// Purpose: watchdog counter with prescaler
// Assumes: counts system clocks while enabled
// Notes:   timeout is a one-cycle pulse when the counter wraps
`timescale 1ns/10ps
`include "sxe_defs.svh"
module sxe_wdt
  import sxe_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // control
  input  wire logic       enable,
  input  wire logic       clear,
  // state
  output logic [7:0]      count_q,
  output logic [7:0]      presc_q,
  output logic            timeout_q
);

  logic presc_tick;
  logic count_wrap;

  assign presc_tick = enable && (presc_q == `SXE_PRESC_MAX);
  assign count_wrap = presc_tick && (count_q == 8'hFF);

  always_ff @(posedge clk_sys) begin
    if (srst || clear) begin
      count_q   <= `SXE_WDT_CLR;
      presc_q   <= `SXE_PRESC_CLR;
      timeout_q <= 1'b0;
    end else begin
      presc_q   <= enable ? presc_q + 8'h01 : presc_q;
      count_q   <= presc_tick ? count_q + 8'h01 : count_q;
      timeout_q <= count_wrap;
    end
  end

endmodule // sxe_wdt

// File: rtl/sxe_core.sv
// Purpose: executes subtract, swap, xor, direction-load and low-power instructions
// Assumes: APB3 slave, software issues one instruction per exec-register write
// Notes:   every access waits while an instruction is in flight
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "sxe_defs.svh"

// What this block does
// - low-power entry clears the power-down flag and sets the time-out flag.
// - low-power entry clears the watchdog counter and its prescaler.
// - file minus work sets carry and digit carry when no borrow occurs, on all bits and low nibble.
// - literal minus work always writes work, with the same carry convention.
// - every subtract updates only carry, digit carry and zero.
// - subtract with borrow takes file minus work minus inverted carry, to work or file by dest.
// - nibble exchange swaps file halves into work or file and touches no flag.
// - direction load copies work into the direction register picked by operand 5, 6 or 7.
// - literal xor writes work xor literal into work and updates only zero.
// - file xor writes work xor file into work or file by dest and updates only zero.
module sxe_core
  import sxe_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SXE_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // port direction outputs
  output logic [7:0]                  port_a_direction,
  output logic [7:0]                  port_b_direction,
  output logic [7:0]                  port_c_direction,
  // low-power entry strobe
  output logic                        sleep_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sxe_state_t  state_q;
  sxe_op_t     op_q;
  logic        dest_q;
  logic [6:0]  faddr_op_q;
  logic [7:0]  lit_q;
  logic [7:0]  work_q;
  logic        c_q;
  logic        dc_q;
  logic        z_q;
  logic        pd_q;
  logic        to_q;
  logic [7:0]  dir_a_q;
  logic [7:0]  dir_b_q;
  logic [7:0]  dir_c_q;
  logic        wdt_en_q;
  logic [6:0]  mem_addr_q;
  logic        rd_pend_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        sleep_q;

  logic [7:0]  wdt_count;
  logic [7:0]  wdt_presc;
  logic        wdt_timeout;

  sxe_mem_if   mem_bus ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire acc       = psel && penable;
  wire eng_busy  = (state_q != ST_IDLE);
  wire sel_exec  = (paddr == `SXE_OFS_EXEC);
  wire sel_work  = (paddr == `SXE_OFS_WORK);
  wire sel_stat  = (paddr == `SXE_OFS_STATUS);
  wire sel_dir   = (paddr == `SXE_OFS_DIR);
  wire sel_wdt   = (paddr == `SXE_OFS_WDT);
  wire sel_wdtc  = (paddr == `SXE_OFS_WDT_CTRL);
  wire sel_faddr = (paddr == `SXE_OFS_FADDR);
  wire sel_fdata = (paddr == `SXE_OFS_FDATA);
  wire hit       = sel_exec || sel_work || sel_stat || sel_dir ||
                   sel_wdt || sel_wdtc || sel_faddr || sel_fdata;
  // write takes effect at the edge where the master sees pready
  wire wr_en     = acc && pready_q && pwrite;
  wire mem_rd    = acc && !pready_q && !pwrite && sel_fdata && !eng_busy && !rd_pend_q;
  wire start     = wr_en && sel_exec;

  wire [31:0] stat_word = {27'h0, to_q, pd_q, z_q, dc_q, c_q};
  wire [31:0] exec_word = {8'h00, lit_q, 1'b0, faddr_op_q, 3'h0, dest_q, op_q};
  wire [31:0] rd_mux =
    sel_exec  ? exec_word :
    sel_work  ? {24'h0, work_q} :
    sel_stat  ? stat_word :
    sel_dir   ? {8'h00, dir_c_q, dir_b_q, dir_a_q} :
    sel_wdt   ? {16'h0, wdt_presc, wdt_count} :
    sel_wdtc  ? {31'h0, wdt_en_q} :
    sel_faddr ? {25'h0, mem_addr_q} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // instruction decode and datapath
  // ----------------------------------------------------------------
  wire exec_now  = (state_q == ST_EXEC);
  wire is_sleep  = (op_q == OP_SLEEP);
  wire is_sub_wf = (op_q == OP_SUB_WF);
  wire is_sub_lw = (op_q == OP_SUB_LW);
  wire is_sub_b  = (op_q == OP_SUB_WFB);
  wire is_sub    = is_sub_wf || is_sub_lw || is_sub_b;
  wire is_swap   = (op_q == OP_NIBBLE_SWAP);
  wire is_load_direction_instr   = (op_q == OP_LOAD_DIR);
  wire is_xor_l  = (op_q == OP_XOR_LIT);
  wire is_xor_f  = (op_q == OP_XOR_FILE);
  wire is_xor    = is_xor_l || is_xor_f;
  wire [7:0] file_val = mem_bus.rdata;

  // minuend is the literal or the file; borrow form feeds carry in as not-borrow
  wire [7:0] sub_a   = is_sub_lw ? lit_q : file_val;
  wire       sub_cin = is_sub_b ? c_q : 1'b1;
  wire [8:0] sub_sum = {1'b0, sub_a} + {1'b0, ~work_q} + {8'h00, sub_cin};
  wire [4:0] nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~work_q[3:0]} + {4'h0, sub_cin};

  wire [7:0] result =
    is_sub   ? sub_sum[7:0] :
    is_swap  ? {file_val[3:0], file_val[7:4]} :
    is_xor_l ? (work_q ^ lit_q) :
               (work_q ^ file_val);
  wire res_zero = (result == 8'h00);

  // destination: literal forms always go to work
  wire to_file = dest_q && (is_sub_wf || is_sub_b || is_swap || is_xor_f);
  wire writes  = is_sub || is_swap || is_xor;
  wire to_work = writes && !to_file;

  // ----------------------------------------------------------------
  // memory port sharing
  // ----------------------------------------------------------------
  wire eng_fetch = (state_q == ST_FETCH);
  wire eng_wr    = exec_now && to_file;
  wire apb_wr    = wr_en && sel_fdata;

  assign mem_bus.en    = eng_fetch || eng_wr || mem_rd || apb_wr;
  assign mem_bus.we    = eng_wr || apb_wr;
  assign mem_bus.addr  = eng_busy ? faddr_op_q : mem_addr_q;
  assign mem_bus.wdata = eng_busy ? result : pwdata[7:0];

  sxe_file_mem u_mem (
    .clk_sys (clk_sys),
    .port    (mem_bus)
  );

  sxe_wdt u_wdt (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .enable    (wdt_en_q),
    .clear     (exec_now && is_sleep),
    .count_q   (wdt_count),
    .presc_q   (wdt_presc),
    .timeout_q (wdt_timeout)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  state_q <= start ? ST_FETCH : ST_IDLE;
        ST_FETCH: state_q <= ST_EXEC;
        ST_EXEC:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_q       <= OP_NOP;
      dest_q     <= 1'b0;
      faddr_op_q <= 7'h00;
      lit_q      <= 8'h00;
    end else if (start) begin
      op_q       <= sxe_op_t'(pwdata[`SXE_EXEC_OP_MSB:`SXE_EXEC_OP_LSB]);
      dest_q     <= pwdata[`SXE_EXEC_DEST_BIT];
      faddr_op_q <= pwdata[`SXE_EXEC_FA_MSB:`SXE_EXEC_FA_LSB];
      lit_q      <= pwdata[`SXE_EXEC_LIT_MSB:`SXE_EXEC_LIT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // work register and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      work_q <= `SXE_WORK_RST;
    end else if (exec_now && to_work) begin
      work_q <= result;
    end else if (wr_en && sel_work) begin
      work_q <= pwdata[7:0];
    end
  end

  // subtracts touch c, dc, z; xor touches z alone; swap and load none
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      z_q  <= 1'b0;
    end else if (exec_now && is_sub) begin
      c_q  <= sub_sum[8];
      dc_q <= nib_sum[4];
      z_q  <= res_zero;
    end else if (exec_now && is_xor) begin
      z_q  <= res_zero;
    end else if (wr_en && sel_stat) begin
      c_q  <= pwdata[`SXE_ST_C];
      dc_q <= pwdata[`SXE_ST_DC];
      z_q  <= pwdata[`SXE_ST_Z];
    end
  end

  // low-power entry outranks a watchdog wrap in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pd_q <= `SXE_PD_RST;
      to_q <= `SXE_TO_RST;
    end else if (exec_now && is_sleep) begin
      pd_q <= 1'b0;
      to_q <= 1'b1;
    end else if (wdt_timeout) begin
      to_q <= 1'b0;
    end else if (wr_en && sel_stat) begin
      pd_q <= pwdata[`SXE_ST_PD];
      to_q <= pwdata[`SXE_ST_TO];
    end
  end

  // ----------------------------------------------------------------
  // direction registers and small controls
  // ----------------------------------------------------------------
  wire load_direction_instr_go = exec_now && is_load_direction_instr;
  wire ld_a    = load_direction_instr_go && (faddr_op_q == `SXE_LOAD_DIRECTION_INSTR_SEL_A);
  wire ld_b    = load_direction_instr_go && (faddr_op_q == `SXE_LOAD_DIRECTION_INSTR_SEL_B);
  wire ld_c    = load_direction_instr_go && (faddr_op_q == `SXE_LOAD_DIRECTION_INSTR_SEL_C);
  wire wr_dir  = wr_en && sel_dir;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dir_a_q <= `SXE_DIR_RST;
      dir_b_q <= `SXE_DIR_RST;
      dir_c_q <= `SXE_DIR_RST;
    end else begin
      dir_a_q <= ld_a ? work_q : (wr_dir ? pwdata[`SXE_DIR_A_LSB+:8] : dir_a_q);
      dir_b_q <= ld_b ? work_q : (wr_dir ? pwdata[`SXE_DIR_B_LSB+:8] : dir_b_q);
      dir_c_q <= ld_c ? work_q : (wr_dir ? pwdata[`SXE_DIR_C_LSB+:8] : dir_c_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wdt_en_q   <= 1'b0;
      mem_addr_q <= 7'h00;
      sleep_q    <= 1'b0;
    end else begin
      wdt_en_q   <= (wr_en && sel_wdtc) ? pwdata[0] : wdt_en_q;
      mem_addr_q <= (wr_en && sel_faddr) ? pwdata[6:0] : mem_addr_q;
      sleep_q    <= exec_now && is_sleep;
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // a file read needs one extra cycle for the memory's registered output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
    end else if (pready_q || !acc || eng_busy) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (sel_fdata && !pwrite) begin
      pready_q  <= rd_pend_q;
      prdata_q  <= rd_pend_q ? {24'h0, mem_bus.rdata} : prdata_q;
      rd_pend_q <= !rd_pend_q;
    end else begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit;
      prdata_q  <= pwrite ? prdata_q : rd_mux;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign port_a_direction = dir_a_q;
  assign port_b_direction = dir_b_q;
  assign port_c_direction = dir_c_q;
  assign sleep_pulse      = sleep_q;

endmodule // sxe_core

// File: sim/sxe_core_chk.sv
// Purpose: port-level checks of the execution block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to sxe_core below
`timescale 1ns/10ps
`include "sxe_defs.svh"
module sxe_core_chk
  import sxe_pkg::*;
(
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   srst,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`SXE_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // outputs
  input wire logic [7:0]             port_a_direction,
  input wire logic [7:0]             port_b_direction,
  input wire logic [7:0]             port_c_direction,
  input wire logic                   sleep_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // recent causes
  // ----------------------------------------------------------------
  wire logic       exec_wr = pready && pwrite && (paddr == `SXE_OFS_EXEC);
  wire logic       dir_wr  = exec_wr || (pready && pwrite && (paddr == `SXE_OFS_DIR));
  wire logic       slp_wr  = exec_wr && (pwdata[3:0] == 4'h1);
  logic      [5:0] dir_hist_q;
  logic      [5:0] slp_hist_q;

  always_ff @(posedge clk_sys) begin
    dir_hist_q <= srst ? 6'h00 : {dir_hist_q[4:0], dir_wr};
    slp_hist_q <= srst ? 6'h00 : {slp_hist_q[4:0], slp_wr};
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_mapped_no_err: assert property (pready && paddr <= `SXE_OFS_FDATA && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped address");
  a_exec_stall: assert property (exec_wr |=> !pready [*3])
    else $error("access answered while instruction runs");
  a_sleep_single: assert property (sleep_pulse |=> !sleep_pulse)
    else $error("sleep pulse too long");
  a_sleep_cause: assert property (sleep_pulse |-> |slp_hist_q)
    else $error("sleep pulse without low-power instruction");
  a_dir_a_cause: assert property ($changed(port_a_direction) |-> |dir_hist_q)
    else $error("port a direction changed without cause");
  a_dir_b_cause: assert property ($changed(port_b_direction) |-> |dir_hist_q)
    else $error("port b direction changed without cause");
  a_dir_c_cause: assert property ($changed(port_c_direction) |-> |dir_hist_q)
    else $error("port c direction changed without cause");

  c_sleep: cover property (sleep_pulse);
  c_error: cover property (pslverr);
  c_dir_c: cover property ($changed(port_c_direction));
endmodule // sxe_core_chk

bind sxe_core sxe_core_chk sxe_core_chk_inst (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction), .sleep_pulse(sleep_pulse)
);

// File: sim/tb_sxe_core.sv
// Purpose: self-checking bench of the execution block over apb
// Assumes: 25 MHz clock, synchronous reset held 10 cycles
// Notes:   file cells are written before use, memory is not reset
`timescale 1ns/10ps
`include "sxe_defs.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, a); end end
module tb_sxe_core
  import sxe_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_c;
  logic        sleep_pulse;
  int          num_errors = 0;
  int          checks     = 0;

  always #20 clk_sys = ~clk_sys;

  sxe_core sxe_core_inst (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_direction(dir_a), .port_b_direction(dir_b), .port_c_direction(dir_c),
    .sleep_pulse(sleep_pulse)
  );

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r);
  endtask

  task automatic setf(input logic [6:0] fa, input logic [7:0] v);
    wr(`SXE_OFS_FADDR, {25'h0, fa});
    wr(`SXE_OFS_FDATA, {24'h0, v});
  endtask

  task automatic chk_f(input logic [6:0] fa, input logic [7:0] v);
    wr(`SXE_OFS_FADDR, {25'h0, fa});
    chk_rd("file", `SXE_OFS_FDATA, {24'h0, v});
  endtask

  task automatic ex(input sxe_op_t op, input logic d, input logic [6:0] fa, input logic [7:0] k);
    wr(`SXE_OFS_EXEC, {8'h00, k, 1'b0, fa, 3'h0, d, op});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk_rd("status", `SXE_OFS_STATUS, 32'h18);
    chk_rd("dir", `SXE_OFS_DIR, 32'h00FFFFFF);
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e);
    `CHK("unmapped data", 32'h0, r);
  endtask

  task automatic t_sub();
    wr(`SXE_OFS_WORK, 32'h01);
    wr(`SXE_OFS_STATUS, 32'h1C);
    setf(7'h03, 8'h10);
    ex(OP_SUB_WF, 1'b0, 7'h03, 8'h00);
    chk_rd("work", `SXE_OFS_WORK, 32'h0F);
    chk_rd("status", `SXE_OFS_STATUS, 32'h19);
    setf(7'h04, 8'h0F);
    ex(OP_SUB_WF, 1'b1, 7'h04, 8'h00);
    chk_f(7'h04, 8'h00);
    chk_rd("status", `SXE_OFS_STATUS, 32'h1F);
    setf(7'h05, 8'h0E);
    ex(OP_SUB_WF, 1'b0, 7'h05, 8'h00);
    chk_rd("work", `SXE_OFS_WORK, 32'hFF);
    chk_rd("status", `SXE_OFS_STATUS, 32'h18);
    ex(OP_SUB_LW, 1'b1, 7'h00, 8'h05);
    chk_rd("work", `SXE_OFS_WORK, 32'h06);
    chk_rd("status", `SXE_OFS_STATUS, 32'h18);
    ex(OP_SUB_LW, 1'b0, 7'h00, 8'hFF);
    chk_rd("work", `SXE_OFS_WORK, 32'hF9);
    chk_rd("status", `SXE_OFS_STATUS, 32'h1B);
  endtask

  task automatic t_borrow();
    wr(`SXE_OFS_WORK, 32'h0F);
    wr(`SXE_OFS_STATUS, 32'h18);
    setf(7'h06, 8'h10);
    ex(OP_SUB_WFB, 1'b1, 7'h06, 8'h00);
    chk_f(7'h06, 8'h00);
    chk_rd("status", `SXE_OFS_STATUS, 32'h1D);
    setf(7'h07, 8'h10);
    ex(OP_SUB_WFB, 1'b0, 7'h07, 8'h00);
    chk_rd("work", `SXE_OFS_WORK, 32'h01);
    chk_rd("status", `SXE_OFS_STATUS, 32'h19);
  endtask

  task automatic t_swap_dir();
    setf(7'h08, 8'hA5);
    ex(OP_NIBBLE_SWAP, 1'b0, 7'h08, 8'h00);
    chk_rd("work", `SXE_OFS_WORK, 32'h5A);
    ex(OP_NIBBLE_SWAP, 1'b1, 7'h08, 8'h00);
    chk_f(7'h08, 8'h5A);
    chk_rd("status", `SXE_OFS_STATUS, 32'h19);
    ex(OP_LOAD_DIR, 1'b0, 7'h04, 8'h00);
    // results land two edges after the exec write; look once they stand
    repeat (3) @(posedge clk_sys);
    `CHK("dir a", 8'hFF, dir_a);
    for (int i = 0; i < 3; i++) begin
      wr(`SXE_OFS_WORK, 32'h30 + i);
      ex(OP_LOAD_DIR, 1'b0, `SXE_LOAD_DIRECTION_INSTR_SEL_A + 7'(i), 8'h00);
    end
    repeat (3) @(posedge clk_sys);
    `CHK("dir a", 8'h30, dir_a);
    `CHK("dir b", 8'h31, dir_b);
    `CHK("dir c", 8'h32, dir_c);
    chk_rd("status", `SXE_OFS_STATUS, 32'h19);
  endtask

  task automatic t_xor();
    wr(`SXE_OFS_WORK, 32'h5A);
    ex(OP_XOR_LIT, 1'b0, 7'h00, 8'h5A);
    chk_rd("status", `SXE_OFS_STATUS, 32'h1D);
    ex(OP_XOR_LIT, 1'b0, 7'h00, 8'h81);
    chk_rd("work", `SXE_OFS_WORK, 32'h81);
    setf(7'h09, 8'h81);
    ex(OP_XOR_FILE, 1'b1, 7'h09, 8'h00);
    chk_f(7'h09, 8'h00);
    chk_rd("status", `SXE_OFS_STATUS, 32'h1D);
    ex(OP_XOR_FILE, 1'b0, 7'h09, 8'h00);
    chk_rd("status", `SXE_OFS_STATUS, 32'h19);
  endtask

  task automatic t_sleep();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    wr(`SXE_OFS_WDT_CTRL, 32'h1);
    repeat (600) @(posedge clk_sys);
    wr(`SXE_OFS_WDT_CTRL, 32'h0);
    apb(1'b0, `SXE_OFS_WDT, 32'h0, r, e);
    `CHK("watchdog ran", 1'b1, r[7:0] != 8'h00);
    wr(`SXE_OFS_STATUS, 32'h0F);
    ex(OP_SLEEP, 1'b0, 7'h00, 8'h00);
    repeat (8) begin
      @(posedge clk_sys);
      if (sleep_pulse === 1'b1) n++;
    end
    `CHK("sleep pulses", 1, n);
    chk_rd("status", `SXE_OFS_STATUS, 32'h17);
    chk_rd("watchdog", `SXE_OFS_WDT, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_sub();
    t_borrow();
    t_swap_dir();
    t_xor();
    t_sleep();
    final_report();
  end

  // whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule // tb_sxe_core
